// ===== design/hvc_map.svh
// Register offsets, field positions and reset values of the value comparator
`ifndef HVC_MAP_SVH
`define HVC_MAP_SVH

`define HVC_ADDR_W        8
`define HVC_OFF_CTRL      8'h00
`define HVC_OFF_GAIN_A    8'h04
`define HVC_OFF_GAIN_B    8'h08
`define HVC_OFF_OFFSET_A  8'h0C
`define HVC_OFF_DEAD_BAND 8'h10
`define HVC_OFF_STATUS    8'h14
`define HVC_OFF_IRQ_STAT  8'h18
`define HVC_OFF_IRQ_MASK  8'h1C

`define HVC_CTRL_MODE_LSB 0
`define HVC_CTRL_MODE_MSB 2
`define HVC_CTRL_GATE_BIT 3

`define HVC_STAT_CONTACT  0
`define HVC_STAT_RANGE    1
`define HVC_STAT_ACTIVE   2

`define HVC_IRQ_CONTACT   0
`define HVC_IRQ_RANGE     1

`define HVC_GAIN_RST      32'sh0000_0001
`define HVC_ZERO_RST      32'sh0000_0000

`define HVC_RESP_OKAY     2'h0
`define HVC_RESP_SLVERR   2'h2

`endif

// ===== design/hvc_pkg.sv
// Types of the value comparator
package hvc_pkg;

  typedef enum logic [2:0] {
    HVC_LESS,
    HVC_LESS_EQUAL,
    HVC_EQUAL,
    HVC_GREATER_EQUAL,
    HVC_GREATER
  } hvc_mode_t;

  typedef struct packed {
    hvc_mode_t   mode;
    logic        gate_opt;
    logic [31:0] gain_a;
    logic [31:0] gain_b;
    logic [31:0] offset_a;
    logic [31:0] dead_band;
    logic        contact;
    logic        range;
    logic        active;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } hvc_state_t;

endpackage

// ===== design/hvc_top.sv
// Signed 32-bit hysteresis value comparator with an AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "hvc_map.svh"

// How it works
// - Gate option set: ENABLE gates the block; cleared: runs always.
// - Greater mode: contact switches on once scaled A reaches scaled B.
// - Greater mode: contact releases only when A falls below B minus band.
// - Less mode: contact switches on once falling A reaches scaled B.
// - Less mode: contact releases only when A rises above B plus band.
// - Offset is added to scaled A before every comparison.
// - Equal mode: on when A equals B, off outside B plus/minus band.
// - Range flag is high while A times gain plus offset overflows 32 bits.
// - Nothing is retained; reset clears all state except mode (greater), both gains (one) and the ready flags.
// - Operands, gains, offset and band are signed 32-bit values.
// - Operand A is multiplied by gain A.
// - The dead band applies symmetrically above and below operand B.
// - Operand B is multiplied by gain B; both gains reset to one.
// - Five mode codes; less and less-equal both set on A <= B, greater and greater-equal both on A >= B.
// - Range flag also covers B and band limits; forces contact low.
module hvc_top (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  // Operands and gate from the controller logic
  input  wire logic signed [31:0]      OPERAND_A,
  input  wire logic signed [31:0]      OPERAND_B,
  input  wire logic                    ENABLE,
  // Comparator results
  output logic                         RESULT_CONTACT,
  output logic                         RANGE_FLAG,
  output logic                         IRQ,
  // AXI4-Lite write channels
  input  wire logic [`HVC_ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [`HVC_ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY
);

  hvc_pkg::hvc_state_t s_q;
  hvc_pkg::hvc_state_t s_d;

  logic signed [65:0] a_cmp;
  logic signed [65:0] b_cmp;
  logic signed [65:0] b_hi;
  logic signed [65:0] b_lo;
  logic               active_c;
  logic               range_c;
  logic               set_c;
  logic               clr_c;
  logic               wr_do;
  logic               rd_do;

  // Upper 35 bits all equal means the value fits in signed 32 bits
  function automatic logic fits32(input logic signed [65:0] x);
    return (&x[65:31]) || ~(|x[65:31]);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `HVC_OFF_CTRL, `HVC_OFF_GAIN_A, `HVC_OFF_GAIN_B, `HVC_OFF_OFFSET_A,
      `HVC_OFF_DEAD_BAND, `HVC_OFF_STATUS, `HVC_OFF_IRQ_STAT,
      `HVC_OFF_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Terms are sign-extended to 66 bits first: a 32x32 product plus a
  // 32-bit term then never wraps, so overflow stays visible
  always_comb begin
    a_cmp = 66'(OPERAND_A) * 66'($signed(s_q.gain_a))
          + 66'($signed(s_q.offset_a));
    b_cmp = 66'(OPERAND_B) * 66'($signed(s_q.gain_b));
    b_hi  = b_cmp + 66'($signed(s_q.dead_band));
    b_lo  = b_cmp - 66'($signed(s_q.dead_band));
  end

  assign active_c = !s_q.gate_opt || ENABLE;
  assign range_c  = !fits32(a_cmp) || !fits32(b_cmp)
                 || !fits32(b_hi) || !fits32(b_lo);

  // Set and release thresholds per relation; between them the contact holds
  always_comb begin
    set_c = 1'b0;
    clr_c = 1'b1;
    case (s_q.mode)
      hvc_pkg::HVC_LESS, hvc_pkg::HVC_LESS_EQUAL: begin
        set_c = a_cmp <= b_cmp;
        clr_c = a_cmp > b_hi;
      end
      hvc_pkg::HVC_EQUAL: begin
        set_c = a_cmp == b_cmp;
        clr_c = (a_cmp > b_hi) || (a_cmp < b_lo);
      end
      hvc_pkg::HVC_GREATER_EQUAL, hvc_pkg::HVC_GREATER: begin
        set_c = a_cmp >= b_cmp;
        clr_c = a_cmp < b_lo;
      end
      default: begin
        set_c = 1'b0;
        clr_c = 1'b1;
      end
    endcase
  end

  assign wr_do = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_do = S_AXI_ARVALID && s_q.arready;

  always_comb begin
    s_d = s_q;

    // Comparator, evaluated every cycle
    s_d.active = active_c;
    if (!active_c) begin
      s_d.contact = 1'b0;
      s_d.range   = 1'b0;
    end else if (range_c) begin
      s_d.contact = 1'b0;
      s_d.range   = 1'b1;
    end else begin
      s_d.range = 1'b0;
      if (set_c) begin
        s_d.contact = 1'b1;
      end else if (clr_c) begin
        s_d.contact = 1'b0;
      end
    end

    // Write address and data are taken in either order
    if (S_AXI_AWVALID && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = is_mapped(s_q.aw_addr) ? `HVC_RESP_OKAY
                                           : `HVC_RESP_SLVERR;
      case (s_q.aw_addr)
        `HVC_OFF_CTRL: begin
          if (s_q.w_strb[0]) begin
            s_d.mode = hvc_pkg::hvc_mode_t'(
              s_q.w_data[`HVC_CTRL_MODE_MSB:`HVC_CTRL_MODE_LSB]);
            s_d.gate_opt = s_q.w_data[`HVC_CTRL_GATE_BIT];
          end
        end
        `HVC_OFF_GAIN_A:
          s_d.gain_a = merge(s_q.gain_a, s_q.w_data, s_q.w_strb);
        `HVC_OFF_GAIN_B:
          s_d.gain_b = merge(s_q.gain_b, s_q.w_data, s_q.w_strb);
        `HVC_OFF_OFFSET_A:
          s_d.offset_a = merge(s_q.offset_a, s_q.w_data, s_q.w_strb);
        `HVC_OFF_DEAD_BAND:
          s_d.dead_band = merge(s_q.dead_band, s_q.w_data, s_q.w_strb);
        `HVC_OFF_IRQ_MASK: begin
          if (s_q.w_strb[0]) begin
            s_d.irq_mask = s_q.w_data[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Reads answer from the registered state one cycle after the address
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = is_mapped(S_AXI_ARADDR) ? `HVC_RESP_OKAY
                                           : `HVC_RESP_SLVERR;
      s_d.rdata  = 32'h0000_0000;
      case (S_AXI_ARADDR)
        `HVC_OFF_CTRL: begin
          s_d.rdata[`HVC_CTRL_MODE_MSB:`HVC_CTRL_MODE_LSB] = s_q.mode;
          s_d.rdata[`HVC_CTRL_GATE_BIT] = s_q.gate_opt;
        end
        `HVC_OFF_GAIN_A:    s_d.rdata = s_q.gain_a;
        `HVC_OFF_GAIN_B:    s_d.rdata = s_q.gain_b;
        `HVC_OFF_OFFSET_A:  s_d.rdata = s_q.offset_a;
        `HVC_OFF_DEAD_BAND: s_d.rdata = s_q.dead_band;
        `HVC_OFF_STATUS: begin
          s_d.rdata[`HVC_STAT_CONTACT] = s_q.contact;
          s_d.rdata[`HVC_STAT_RANGE]   = s_q.range;
          s_d.rdata[`HVC_STAT_ACTIVE]  = s_q.active;
        end
        `HVC_OFF_IRQ_STAT: s_d.rdata[1:0] = s_q.irq_stat;
        `HVC_OFF_IRQ_MASK: s_d.rdata[1:0] = s_q.irq_mask;
        default: begin
        end
      endcase
      if (S_AXI_ARADDR == `HVC_OFF_IRQ_STAT) begin
        s_d.irq_stat = 2'h0;
      end
    end

    // Events are ORed in after the read clear so a same-cycle event survives
    if (s_d.contact && !s_q.contact) begin
      s_d.irq_stat[`HVC_IRQ_CONTACT] = 1'b1;
    end
    if (s_d.range && !s_q.range) begin
      s_d.irq_stat[`HVC_IRQ_RANGE] = 1'b1;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q           <= '0;
      s_q.mode      <= hvc_pkg::HVC_GREATER;
      s_q.gain_a    <= `HVC_GAIN_RST;
      s_q.gain_b    <= `HVC_GAIN_RST;
      s_q.offset_a  <= `HVC_ZERO_RST;
      s_q.dead_band <= `HVC_ZERO_RST;
      s_q.awready   <= 1'b1;
      s_q.wready    <= 1'b1;
      s_q.arready   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign RESULT_CONTACT = s_q.contact;
  assign RANGE_FLAG     = s_q.range;
  assign IRQ            = s_q.irq;
  assign S_AXI_AWREADY  = s_q.awready;
  assign S_AXI_WREADY   = s_q.wready;
  assign S_AXI_BVALID   = s_q.bvalid;
  assign S_AXI_BRESP    = s_q.bresp;
  assign S_AXI_ARREADY  = s_q.arready;
  assign S_AXI_RVALID   = s_q.rvalid;
  assign S_AXI_RDATA    = s_q.rdata;
  assign S_AXI_RRESP    = s_q.rresp;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_range_forces_low: assert property (
    RANGE_FLAG |-> !RESULT_CONTACT)
    else $error("contact high while range flag set");
  a_gate_holds_zero: assert property (
    (s_q.gate_opt && !ENABLE) |=> (!RESULT_CONTACT && !RANGE_FLAG))
    else $error("outputs not zero while gated off");
  a_free_run_on: assert property (
    (!s_q.gate_opt && !ENABLE && !range_c && set_c) |=> RESULT_CONTACT)
    else $error("enable input not ignored with gate option clear");
  a_gt_switch_on: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_GREATER
     && a_cmp >= b_cmp) |=> RESULT_CONTACT)
    else $error("greater mode did not switch on at setpoint");
  a_gt_release: assert property (
    (RESULT_CONTACT && s_q.mode == hvc_pkg::HVC_GREATER
     && a_cmp >= b_lo) |=> (RESULT_CONTACT || !$past(active_c)
                             || $past(range_c)))
    else $error("greater mode released inside the band");
  a_lt_switch_on: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_LESS
     && a_cmp <= b_cmp) |=> RESULT_CONTACT)
    else $error("less mode did not switch on at setpoint");
  // A negative band flips the limits, so releases also demand A off B
  a_lt_release: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_LESS
     && a_cmp > b_hi && a_cmp > b_cmp) |=> !RESULT_CONTACT)
    else $error("less mode did not release above band");
  a_eq_band_off: assert property (
    (active_c && s_q.mode == hvc_pkg::HVC_EQUAL && a_cmp != b_cmp
     && (a_cmp > b_hi || a_cmp < b_lo)) |=> !RESULT_CONTACT)
    else $error("equal mode did not release outside band");
  a_range_tracks: assert property (
    active_c |=> (RANGE_FLAG == $past(range_c)))
    else $error("range flag does not follow overflow");
  a_gain_reset_one: assert property (
    $fell(RESET) |-> (s_q.gain_a == 32'h0000_0001
                       && s_q.gain_b == 32'h0000_0001))
    else $error("gains not one after reset");
  a_eq_switch_on: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_EQUAL
     && a_cmp == b_cmp) |=> RESULT_CONTACT)
    else $error("equal mode did not switch on at match");
  a_le_switch_on: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_LESS_EQUAL
     && a_cmp <= b_cmp) |=> RESULT_CONTACT)
    else $error("less-equal mode did not switch on");
  a_ge_switch_on: assert property (
    (active_c && !range_c && s_q.mode == hvc_pkg::HVC_GREATER_EQUAL
     && a_cmp >= b_cmp) |=> RESULT_CONTACT)
    else $error("greater-equal mode did not switch on");
  a_bad_mode_off: assert property (
    (s_q.mode > hvc_pkg::HVC_GREATER) |=> !RESULT_CONTACT)
    else $error("contact set with an unused mode code");
  a_lt_hold_band: assert property (
    (RESULT_CONTACT && s_q.mode == hvc_pkg::HVC_LESS
     && a_cmp <= b_hi) |=> (RESULT_CONTACT || !$past(active_c)
                             || $past(range_c)))
    else $error("less mode released inside the band");

  c_gt_cycle: cover property (
    s_q.mode == hvc_pkg::HVC_GREATER && $rose(RESULT_CONTACT)
    ##[1:50] $fell(RESULT_CONTACT));
  c_eq_hit: cover property (
    s_q.mode == hvc_pkg::HVC_EQUAL && $rose(RESULT_CONTACT));
  c_range_irq: cover property ($rose(RANGE_FLAG) ##[1:4] IRQ);
  c_write_read: cover property (S_AXI_BVALID ##[1:20] S_AXI_RVALID);
  c_gate_on: cover property (s_q.gate_opt && $rose(RESULT_CONTACT));

endmodule // hvc_top

// ===== test/hvc_ctl_model.sv
// Controller-side operand source for the value comparator
`timescale 1ns/100ps
module hvc_ctl_model (
  // Clock
  input  wire logic          clk,
  // Operands and gate towards the comparator
  output logic signed [31:0] opa,
  output logic signed [31:0] opb,
  output logic               en
);
  initial begin
    opa = 32'sh0;
    opb = 32'sh0;
    en  = 1'b0;
  end

  // Values change only right after an edge, so the block never sees a race
  task automatic put(input logic [31:0] a, input logic [31:0] b,
                     input logic e);
    @(posedge clk);
    opa <= a;
    opb <= b;
    en  <= e;
  endtask
endmodule // hvc_ctl_model

// ===== test/tb_top.sv
// Self-checking bench of the value comparator
`timescale 1ns/100ps
`include "hvc_map.svh"
module tb_top;
  localparam logic [1:0] OK = `HVC_RESP_OKAY;
  localparam logic [1:0] ER = `HVC_RESP_SLVERR;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic signed [31:0] opa;
  logic signed [31:0] opb;
  logic               en;
  logic               contact;
  logic               rng;
  logic               irq;
  logic [7:0]         awaddr = 8'h0;
  logic [7:0]         araddr = 8'h0;
  logic [31:0]        wdata = 32'h0;
  logic [31:0]        rdata;
  logic [1:0]         bresp;
  logic [1:0]         rresp;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic               awready;
  logic               wready;
  logic               bvalid;
  logic               arready;
  logic               rvalid;
  int                 errors = 0;
  int                 n_tests = 0;
  int                 cyc = 0;

  always #4 clk = ~clk;

  hvc_ctl_model ctl_u (.clk(clk), .opa(opa), .opb(opb), .en(en));

  hvc_top dut_u (
    .CLK(clk), .RESET(reset), .OPERAND_A(opa), .OPERAND_B(opb),
    .ENABLE(en), .RESULT_CONTACT(contact), .RANGE_FLAG(rng), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Address and data go out together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask

  // Results lag the operands by one edge
  task automatic step(input logic [31:0] a, input logic [31:0] b,
                      input logic e, input logic c, input logic r);
    ctl_u.put(a, b, e);
    @(posedge clk);
    #1;
    chk({31'h0, contact}, {31'h0, c});
    chk({31'h0, rng}, {31'h0, r});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_reset_values();
    rd(`HVC_OFF_CTRL, 32'h4, OK);
    rd(`HVC_OFF_GAIN_A, 32'h1, OK);
    rd(`HVC_OFF_GAIN_B, 32'h1, OK);
    rd(8'h20, 32'h0, ER);
  endtask

  task automatic t_modes();
    wr(`HVC_OFF_DEAD_BAND, 32'h2, OK);
    step(32'h2, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h4, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h3, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h2, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h3, OK);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h2, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h0, OK);
    step(32'h8, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h6, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h7, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h8, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h1, OK);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h8, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h2, OK);
    step(32'h6, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h7, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h8, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h3, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h2, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h5, OK);
    step(32'h5, 32'h5, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_scale_range();
    wr(`HVC_OFF_CTRL, 32'h4, OK);
    wr(`HVC_OFF_DEAD_BAND, 32'h0, OK);
    wr(`HVC_OFF_GAIN_A, 32'h3, OK);
    wr(`HVC_OFF_OFFSET_A, 32'hFFFF_FFF6, OK);
    wr(`HVC_OFF_GAIN_B, 32'h2, OK);
    step(32'h6, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h7, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h7FFF_FFFF, 32'h5, 1'b0, 1'b0, 1'b1);
    step(32'h7, 32'h5, 1'b0, 1'b1, 1'b0);
    wr(`HVC_OFF_GAIN_A, 32'h1, OK);
    wr(`HVC_OFF_OFFSET_A, 32'h1, OK);
    step(32'h7FFF_FFFE, 32'h5, 1'b0, 1'b1, 1'b0);
    step(32'h7FFF_FFFF, 32'h5, 1'b0, 1'b0, 1'b1);
    step(32'h0, 32'h4000_0000, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic t_gate();
    wr(`HVC_OFF_OFFSET_A, 32'h0, OK);
    wr(`HVC_OFF_GAIN_B, 32'h1, OK);
    wr(`HVC_OFF_CTRL, 32'hC, OK);
    step(32'h5, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b1, 1'b1, 1'b0);
    wr(`HVC_OFF_CTRL, 32'h4, OK);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
  endtask

  // Status bits were set earlier while the mask was still clear
  task automatic t_irq();
    chk({31'h0, irq}, 32'h0);
    wr(`HVC_OFF_IRQ_MASK, 32'h3, OK);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    rd(`HVC_OFF_IRQ_STAT, 32'h3, OK);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    wr(`HVC_OFF_IRQ_MASK, 32'h0, OK);
    step(32'h2, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr(`HVC_OFF_IRQ_MASK, 32'h3, OK);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    rd(`HVC_OFF_IRQ_STAT, 32'h1, OK);
    rd(`HVC_OFF_STATUS, 32'h5, OK);
    wr(`HVC_OFF_STATUS, 32'h0, OK);
    rd(`HVC_OFF_STATUS, 32'h5, OK);
    wr(8'h20, 32'h1, ER);
  endtask

  task automatic t_restart();
    wr(`HVC_OFF_GAIN_A, 32'h3, OK);
    wr(`HVC_OFF_DEAD_BAND, 32'h7, OK);
    step(32'hFFFF_FFF0, 32'h5, 1'b0, 1'b0, 1'b0);
    step(32'h5, 32'h5, 1'b0, 1'b1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({30'h0, contact, irq}, 32'h0);
    rd(`HVC_OFF_GAIN_A, 32'h1, OK);
    rd(`HVC_OFF_DEAD_BAND, 32'h0, OK);
    rd(`HVC_OFF_IRQ_MASK, 32'h0, OK);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_modes();
    t_scale_range();
    t_gate();
    t_irq();
    t_restart();
    report_and_stop();
  end
endmodule // tb_top
